/* File: core/dls_map.vh */
`ifndef DLS_MAP_VH
`define DLS_MAP_VH
`define DLS_SYNC_DELAY 8'h10
`define DLS_SYNC_LOW 8'h80
`define DLS_SYNC_HIGH 8'h01
`define DLS_LONG_BIT 8'h20
`define DLS_BIT_SAMPLE 8'h0A
`define DLS_CMD_STEP 8'h10
`define DLS_CNT_ONE 8'h01
`define DLS_CNT_ZERO 8'h00
`define DLS_DIV_ZERO 16'h0000
`endif

/* File: core/dls_rate_div.v */
`include "dls_map.vh"
`default_nettype none
module dls_rate_div #(
  parameter [15:0] DIV = 16'h0004
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Resync of the tick phase
  input wire restart,
  // One-cycle tick per debug serial cycle
  output reg tick
);
  reg [15:0] cnt_q;

  // Divider; restart aligns ticks with a pin edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `DLS_DIV_ZERO;
      tick <= 1'b0;
    end else if (restart || cnt_q == DIV - 16'h0001) begin
      cnt_q <= `DLS_DIV_ZERO;
      tick <= !restart;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: core/dls_debug_link.v */
`include "dls_map.vh"
`default_nettype none
module dls_debug_link #(
  parameter [15:0] DIV = 16'h0004,
  parameter CMD_BITS = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Debug pin, open drain style
  input wire bkgdPinIn,
  output reg bkgdPinOut,
  output reg bkgdPinOe,
  // Debug mode status from the core
  input wire debugModeActive,
  input wire instrRetired,
  // Core control
  output reg userRunEn,
  output reg stepDone,
  // Command side
  output reg [CMD_BITS-1:0] cmdData,
  output reg cmdValid,
  output reg cmdUnknown,
  input wire ackRequest,
  output reg resyncPulse
);
  // Link walk, all counts in serial ticks of DIV clocks each:
  // Idle line rests high through the external pull-up.
  // Host falling edge opens a bit window and restarts the divider.
  // Bit value is the synced pin level at tick 10 of the window.
  // Window keeps counting past the rising edge, so a short low reads as one.
  // A low still standing after tick 32 is a resync request.
  // Resync drops the partial shift, the bit count and any pending ack.
  // Then wait for the host to let the line go high again.
  // Then 16 quiet ticks, so the host speedup pulse has surely ended.
  // Then own low drive of 128 ticks, the host's timing reference.
  // Then one tick of own high drive for a fast rising edge.
  // Then full release, back to idle and ready for the next falling edge.
  //
  // Divider phase:
  // Only host edges seen while idle restart the divider.
  // Our own falling edge must not restart it, or the reference
  // pulse would be stretched by the synchroniser latency.
  //
  // Pin synchroniser:
  // Three flops; a change only counts when stages 2 and 3 agree.
  // This costs three to four clocks of latency on every host edge.
  // The latency hits both edges of a bit alike, so widths hold.
  //
  // Single step:
  // Step code while debug mode is active raises the user run enable.
  // The core lowers nothing itself; one retired instruction ends it.
  // Step code outside debug mode is flagged and never acknowledged.
  // Other codes are handed on with a one-clock valid pulse.
  //
  // Limitations:
  // A resync that starts after seven bits completes that command first,
  // because tick 10 of the resync low samples an eighth zero bit.
  // Bit sampling is ignored while the response or a step is running.
  // Host lows sampled on fewer than two clocks raise no falling edge.
  //
  // Outputs:
  // Pin drive and enable are registered, so no glitch reaches the pad.
  // Pulse outputs stand for exactly one clock.
  // Command data holds the last full command until the next one.
  //
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WAITHI = 3'd1;
  localparam [2:0] ST_DELAY = 3'd2;
  localparam [2:0] ST_LOW = 3'd3;
  localparam [2:0] ST_HIGH = 3'd4;
  localparam [2:0] ST_STEP = 3'd5;

  reg [2:0] pinSync_q;
  reg pinPrev_q;
  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [7:0] lowCnt_q;
  reg [CMD_BITS-1:0] shift_q;
  reg [3:0] bitCnt_q;
  reg ackPend_q;
  reg inLow_q;
  wire tick;
  wire pinLvl = pinSync_q[2];
  wire pinStable = pinSync_q[1] == pinSync_q[2];
  wire fallEdge = pinStable && !pinLvl && pinPrev_q;
  // Long low only while the line really is still low
  wire longLow = inLow_q && !pinLvl && lowCnt_q > `DLS_LONG_BIT && state_q == ST_IDLE;

  dls_rate_div #(.DIV(DIV)) uDiv (
    .clk(clk),
    .rst(rst),
    .restart(fallEdge && state_q == ST_IDLE), // Own drive must not re-phase ticks
    .tick(tick)
  );

  // Three-stage pin synchroniser; a change counts when stages 2 and 3 agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync_q <= 3'b111;
      pinPrev_q <= 1'b1;
    end else begin
      pinSync_q <= {pinSync_q[1:0], bkgdPinIn};
      if (pinStable) pinPrev_q <= pinLvl;
    end
  end

  // Ticks since the last host falling edge, saturating;
  // runs on past the rising edge so one bits still reach the sample point
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt_q <= `DLS_CNT_ZERO;
      inLow_q <= 1'b0;
    end else if (fallEdge && state_q == ST_IDLE) begin
      lowCnt_q <= `DLS_CNT_ZERO;
      inLow_q <= 1'b1;
    end else if (state_q != ST_IDLE) begin
      inLow_q <= 1'b0;
    end else if (inLow_q && tick && lowCnt_q != 8'hFF) begin
      lowCnt_q <= lowCnt_q + `DLS_CNT_ONE;
    end
  end

  // Main sequencer: bit receive, resync answer, single step
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= `DLS_CNT_ZERO;
      shift_q <= {CMD_BITS{1'b0}};
      bitCnt_q <= 4'h0;
      ackPend_q <= 1'b0;
      bkgdPinOut <= 1'b1;
      bkgdPinOe <= 1'b0;
      cmdData <= {CMD_BITS{1'b0}};
      cmdValid <= 1'b0;
      cmdUnknown <= 1'b0;
      userRunEn <= 1'b0;
      stepDone <= 1'b0;
      resyncPulse <= 1'b0;
    end else begin
      cmdValid <= 1'b0;
      cmdUnknown <= 1'b0;
      stepDone <= 1'b0;
      resyncPulse <= 1'b0;
      if (ackRequest) ackPend_q <= 1'b1;
      case (state_q)
        ST_IDLE: begin
          if (longLow) begin
            // Soft reset: drop partial command and any pending ack
            shift_q <= {CMD_BITS{1'b0}};
            bitCnt_q <= 4'h0;
            ackPend_q <= 1'b0;
            resyncPulse <= 1'b1;
            state_q <= ST_WAITHI;
          end else if (inLow_q && tick && lowCnt_q == `DLS_BIT_SAMPLE) begin
            // Sample bit: still low means zero
            shift_q <= {shift_q[CMD_BITS-2:0], pinLvl};
            if (bitCnt_q == CMD_BITS - 1) begin
              bitCnt_q <= 4'h0;
              cmdData <= {shift_q[CMD_BITS-2:0], pinLvl};
              if ({shift_q[CMD_BITS-2:0], pinLvl} == `DLS_CMD_STEP && debugModeActive) begin
                userRunEn <= 1'b1;
                state_q <= ST_STEP;
              end else if ({shift_q[CMD_BITS-2:0], pinLvl} == `DLS_CMD_STEP) begin
                cmdUnknown <= 1'b1;
              end else begin
                cmdValid <= 1'b1;
              end
            end else begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_WAITHI: begin
          if (pinStable && pinLvl) begin
            cnt_q <= `DLS_CNT_ZERO;
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (tick) begin
            if (cnt_q == `DLS_SYNC_DELAY - `DLS_CNT_ONE) begin
              cnt_q <= `DLS_CNT_ZERO;
              bkgdPinOut <= 1'b0;
              bkgdPinOe <= 1'b1;
              state_q <= ST_LOW;
            end else begin
              cnt_q <= cnt_q + `DLS_CNT_ONE;
            end
          end
        end
        ST_LOW: begin
          if (tick) begin
            if (cnt_q == `DLS_SYNC_LOW - `DLS_CNT_ONE) begin
              cnt_q <= `DLS_CNT_ZERO;
              bkgdPinOut <= 1'b1;
              state_q <= ST_HIGH;
            end else begin
              cnt_q <= cnt_q + `DLS_CNT_ONE;
            end
          end
        end
        ST_HIGH: begin
          if (tick) begin
            bkgdPinOe <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_STEP: begin
          // One instruction only, then back to debug firmware
          if (instrRetired) begin
            userRunEn <= 1'b0;
            stepDone <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/dls_host_model.sv */
`default_nettype none
module dls_host_model (
  // Clock in, pin drive out
  input wire logic clk,
  output logic hostOe = 1'b0,
  output logic hostOut = 1'b1
);
  timeunit 1ns / 1ps;
  task automatic drv(input logic oe, input logic v, input int n);
    {hostOe, hostOut} = {oe, v};
    repeat (n) @(negedge clk);
  endtask
  // Long low, one-cycle speedup, then let the pull-up hold the line
  task automatic resync();
    drv(1, 0, 520);
    drv(1, 1, 1);
    drv(0, 1, 1);
  endtask
  // MSB first; a low shorter than the sample point reads as one
  task automatic send(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      drv(1, 0, d[i] ? 16 : 52);
      drv(0, 1, d[i] ? 60 : 24);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/dls_debug_link_sva.sv */
`default_nettype none
module dls_debug_link_sva #(parameter int DIV = 4) (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic bkgdPinIn,
  input wire logic bkgdPinOut,
  input wire logic bkgdPinOe,
  input wire logic instrRetired,
  input wire logic userRunEn,
  input wire logic stepDone,
  input wire logic cmdUnknown,
  input wire logic resyncPulse
);
  timeunit 1ns / 1ps;
  logic [15:0] low_q;
  // Length of the current own low drive
  always_ff @(posedge clk or posedge rst)
    low_q <= (rst || bkgdPinOut || !bkgdPinOe) ? '0 : low_q + 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pin timing and step control
  chk_sync_low: assert property ($rose(bkgdPinOe) |-> !bkgdPinOut) else $error("start");
  chk_sync_len: assert property ($rose(bkgdPinOut) && bkgdPinOe |-> low_q == 128 * DIV)
    else $error("low length");
  chk_speedup: assert property ($rose(bkgdPinOut) && bkgdPinOe |->
    (bkgdPinOe && bkgdPinOut) [*4] ##1 !bkgdPinOe) else $error("speedup");
  chk_sync_wait: assert property ($rose(bkgdPinOe) |->
    $past(bkgdPinIn, 60) && !$past(bkgdPinIn, 76)) else $error("delay");
  chk_resync_low: assert property (resyncPulse |-> !$past(bkgdPinIn, 120))
    else $error("short low");
  chk_no_ack: assert property (cmdUnknown |=> !bkgdPinOe [*8]) else $error("ack");
  chk_one_instr: assert property (userRunEn && instrRetired |=> !userRunEn)
    else $error("overrun");
  chk_step_done: assert property (userRunEn && instrRetired |-> ##[0:4] stepDone)
    else $error("no done");
  // Main paths reached
  cover property ($rose(bkgdPinOe));
  cover property (stepDone);
  cover property (cmdUnknown);
endmodule
`default_nettype wire

/* File: bench/dls_debug_link_sync_trace_test.sv */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0h got %h want %h", $time, a, b); end end
module dls_debug_link_sync_trace_test;
  timeunit 1ns / 1ps;
  logic clk = 0, rst = 1, debugModeActive = 0, instrRetired = 0, ackRequest = 0;
  wire bkgdPinOut, bkgdPinOe, hostOe, hostOut, userRunEn, stepDone, cmdValid, cmdUnknown;
  wire resyncPulse;
  wire [7:0] cmdData;
  wire bkgdPinIn = bkgdPinOe ? bkgdPinOut : hostOe ? hostOut : 1'b1; // Pulled up when free
  int failures = 0, cmp_count = 0, lowLen = 0, nStep = 0, nUnk = 0, nValid = 0, nSync = 0;
  localparam int DIV = 4; // Clocks per serial tick
  dls_host_model u_host (
    .clk(clk),
    .hostOe(hostOe),
    .hostOut(hostOut)
  );
  dls_debug_link #(.DIV(16'h0004)) u_dut (
    .clk(clk),
    .rst(rst),
    .bkgdPinIn(bkgdPinIn),
    .bkgdPinOut(bkgdPinOut),
    .bkgdPinOe(bkgdPinOe),
    .debugModeActive(debugModeActive),
    .instrRetired(instrRetired),
    .userRunEn(userRunEn),
    .stepDone(stepDone),
    .cmdData(cmdData),
    .cmdValid(cmdValid),
    .cmdUnknown(cmdUnknown),
    .ackRequest(ackRequest),
    .resyncPulse(resyncPulse)
  );
  always #5 clk = ~clk; // 100 MHz
  // Pulse tallies and own low drive length
  always @(posedge clk) begin
    nStep += (stepDone === 1'b1);
    nUnk += (cmdUnknown === 1'b1);
    nValid += (cmdValid === 1'b1);
    nSync += (resyncPulse === 1'b1);
    lowLen += (bkgdPinOe === 1'b1 && bkgdPinOut === 1'b0);
  end
  task automatic t_sync(input int part);
    u_host.send(8'h5A, part);
    nSync = 0;
    u_host.resync();
    lowLen = 0;
    repeat (700) @(negedge clk);
    `CHK(lowLen, 128 * DIV)
    `CHK(nSync, 1)
    `CHK(bkgdPinOe, 1'b0)
  endtask
  task automatic t_cmd(input logic [7:0] d, input int unk);
    nUnk = 0;
    nValid = 0;
    u_host.send(d, 8);
    repeat (20) @(negedge clk);
    `CHK(cmdData, d)
    `CHK(nValid, d != 8'h10)
    `CHK(nUnk, unk)
  endtask
  task automatic t_step();
    debugModeActive = 1;
    nStep = 0;
    repeat (2) begin
      t_cmd(8'h10, 0);
      `CHK(userRunEn, 1'b1)
      instrRetired = 1;
      @(negedge clk) instrRetired = 0;
      `CHK(userRunEn, 1'b0)
      repeat (4) @(negedge clk);
    end
    `CHK(nStep, 2)
    debugModeActive = 0;
    t_cmd(8'h10, 1);
  endtask
  initial begin // Sync pipe needs a few edges after reset
    #80 rst = 0;
    repeat (4) @(negedge clk);
    t_sync(0);
    t_cmd(8'hC3, 0);
    t_step();
    t_sync(3);
    t_cmd(8'hA5, 0);
    summarize(0);
  end
  initial #200us summarize(1); // Tests need about 60 us
  task automatic summarize(input int late);
    failures += late;
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule
bind dls_debug_link dls_debug_link_sva #(.DIV(DIV)) u_chk (
  .clk(clk),
  .rst(rst),
  .bkgdPinIn(bkgdPinIn),
  .bkgdPinOut(bkgdPinOut),
  .bkgdPinOe(bkgdPinOe),
  .instrRetired(instrRetired),
  .userRunEn(userRunEn),
  .stepDone(stepDone),
  .cmdUnknown(cmdUnknown),
  .resyncPulse(resyncPulse)
);
`default_nettype wire
